// ==== hdl/ctc_pkg.sv ====
// shared constants and types of the command encoder test checker
package ctc_pkg;
  localparam int          DW         = 16;
  localparam int          INFO_W     = 48;
  localparam int          PAR_W      = 15;
  localparam int          COPY_D     = 64;
  localparam int          HIST_D     = 256;
  localparam logic [15:0] CI_ADDR    = 16'h0010;
  localparam logic [15:0] DATA_ADDR  = 16'h0040;
  localparam logic [15:0] MSG_ADDR   = 16'h00d0;
  localparam int          MSG_HI_BIT = 15;
  localparam int          MSG_NCI_BIT = 14;
  localparam int          MSG_NBD_BIT = 13;
  localparam int          VAL_BBB_BIT = 0;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;
  localparam logic [15:0] ONES_WORD  = 16'hffff;
  localparam logic [15:0] ALT_WORD   = 16'h5555;
  localparam logic [15:0] SYNC_WORD  = 16'heb90;
  localparam logic [15:0] FLIP_MASK  = 16'h0001;
  localparam logic [14:0] BCH_POLY   = 15'h4a7b;
  localparam logic [1:0]  SYM_ZERO   = 2'h0;
  localparam logic [1:0]  SYM_PLUS   = 2'h1;
  localparam logic [1:0]  SYM_MINUS  = 2'h2;
  localparam int          CLK_HZ     = 10000000;
  localparam int          VAL_WIN_MS = 30;
  localparam int          VAL_WIN_CYC = CLK_HZ / 1000 * VAL_WIN_MS;

  typedef enum logic [2:0] {
    PAT_ZERO  = 3'h0,
    PAT_ONES  = 3'h1,
    PAT_ALT   = 3'h2,
    PAT_COUNT = 3'h3,
    PAT_USER  = 3'h4
  } ctc_pat_t;

  typedef enum logic [1:0] {
    FLT_NONE = 2'h0,
    FLT_WORD = 2'h1,
    FLT_POS  = 2'h2,
    FLT_NTH  = 2'h3
  } ctc_flt_t;

  typedef enum logic [1:0] {
    VOI_ALT1 = 2'h0,
    VOI_ALT2 = 2'h1,
    VOI_WALK = 2'h2
  } ctc_voice_t;

  typedef enum logic [2:0] {
    G_IDLE = 3'h0,
    G_CI   = 3'h1,
    G_DATA = 3'h2,
    G_MSG  = 3'h3,
    G_WAIT = 3'h4,
    G_DONE = 3'h5
  } ctc_gen_t;
endpackage

// ==== hdl/ctc_bch_if.sv ====
// request and answer signals between checker and parity regenerator
`timescale 1ns/100ps
interface ctc_bch_if;
  logic                         start;
  logic [ctc_pkg::INFO_W-1:0]   info;
  logic [ctc_pkg::PAR_W-1:0]    parity;
  logic                         done;
  modport gen (input start, input info, output parity, output done);
  modport use_side (output start, output info, input parity, input done);
endinterface

// ==== hdl/ctc_bch_enc.sv ====
// bch parity regenerator for the 48-bit formatted command
`timescale 1ns/100ps
module ctc_bch_enc #(
  parameter logic [ctc_pkg::PAR_W-1:0] POLY = ctc_pkg::BCH_POLY
) (
  input wire logic clk,
  input wire logic rst,
  ctc_bch_if.gen   b
);
  logic [ctc_pkg::PAR_W-1:0] par_reg;
  logic                      done_reg;

  // whole division in one cycle; the slow clock leaves ample margin
  function automatic logic [ctc_pkg::PAR_W-1:0] calc(
    input logic [ctc_pkg::INFO_W-1:0] d);
    logic [ctc_pkg::PAR_W-1:0] r;
    logic                      fb;
    r = '0;
    for (int i = ctc_pkg::INFO_W - 1; i >= 0; i--)
    begin
      fb = d[i] ^ r[ctc_pkg::PAR_W-1];
      r  = {r[ctc_pkg::PAR_W-2:0], 1'b0};
      if (fb)
        r = r ^ POLY;
    end
    return r;
  endfunction

  always_ff @(posedge clk)
  begin
    if (rst)
      par_reg <= '0;
    else if (b.start)
      par_reg <= calc(b.info);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      done_reg <= 1'b0;
    else
      done_reg <= b.start;
  end

  assign b.parity = par_reg;
  assign b.done   = done_reg;
endmodule

// ==== hdl/ctc_top.sv ====
// command encoder test checker: stimulus, monitor, loopback, voice, check
// Behaviour
// - five payload patterns: zeros, ones, alternating, count, user
// - operator picks words to leave unvalidated
// - faulty word: flip bit, else late acknowledgement
// - count blocks, retransmissions, keep last 256 bits
// - any mismatch halts run, holds recorded state
// - encrypter symbols looped back plain or inverted
// - voice patterns: single alternation, pairs, walking bit
// - regenerate bch parity, compare, flag difference
// - keep sent data words, compare received
// - deserialise, find sync, mode select, parallel out
// - parallel address, data, strobe into two-port memory
// - run settings latched at run start
`timescale 1ns/100ps
module ctc_top #(
  parameter int VAL_WIN_CYC = ctc_pkg::VAL_WIN_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run_start,
  input  wire logic [2:0]  pat_mode,
  input  wire logic [15:0] pat_user,
  input  wire logic [7:0]  payload_addr,
  input  wire logic [4:0]  fmt_type,
  input  wire logic [2:0]  verif_sel,
  input  wire logic [5:0]  blk_len,
  input  wire logic        priority_hi,
  input  wire logic [8:0]  num_blocks,
  input  wire logic [3:0]  retx_cnt,
  input  wire logic [1:0]  fault_mode,
  input  wire logic [15:0] fault_n,
  input  wire logic        blk_taken,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic        tx_valid,
  input  wire logic [15:0] tx_word,
  output logic             pms_valid,
  output logic [15:0]      pms_word,
  output logic             pms_ack,
  input  wire logic        enc_in_valid,
  input  wire logic [1:0]  enc_in_sym,
  input  wire logic        lb_invert,
  output logic             lb_valid,
  output logic [1:0]       lb_sym,
  input  wire logic [1:0]  voice_pat,
  input  wire logic        voice_tick,
  output logic             voice_bit,
  input  wire logic        rx_valid,
  input  wire logic        rx_bit,
  input  wire logic        bch_mode,
  output logic             rx_word_valid,
  output logic [15:0]      rx_word,
  output logic             halted,
  output logic             parity_err,
  output logic [15:0]      blk_rx_cnt,
  output logic [15:0]      retx_rx_cnt,
  input  wire logic [7:0]  hist_sel,
  output logic             hist_bit,
  output logic             run_busy
);
  ctc_pkg::ctc_gen_t   g_st_reg;
  ctc_pkg::ctc_pat_t   cfg_pat_reg;
  logic [15:0]         cfg_user_reg;
  logic [7:0]          cfg_addr_reg;
  logic [4:0]          cfg_fmt_reg;
  logic [2:0]          cfg_verif_reg;
  logic [5:0]          cfg_len_reg;
  logic                cfg_hi_reg;
  logic [8:0]          cfg_blocks_reg;
  logic [3:0]          cfg_retx_reg;
  logic [1:0]          cfg_flt_reg;
  logic [15:0]         cfg_fn_reg;
  logic [5:0]          widx_reg;
  logic [8:0]          blk_left_reg;
  logic [15:0]         cnt_reg;
  logic                first_reg;
  logic [15:0]         copy_reg [ctc_pkg::COPY_D];
  logic [15:0]         pat_word;
  logic [15:0]         ci_word;
  logic                start_ok;
  logic                stop;

  assign start_ok = run_start
                  && (g_st_reg == ctc_pkg::G_IDLE || g_st_reg == ctc_pkg::G_DONE);
  assign stop     = halted;
  assign run_busy = g_st_reg != ctc_pkg::G_IDLE && g_st_reg != ctc_pkg::G_DONE;

  // settings held for the whole run so mid-run changes cannot skew checks
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_pat_reg    <= ctc_pkg::PAT_ZERO;
      cfg_user_reg   <= ctc_pkg::ZERO_WORD;
      cfg_addr_reg   <= '0;
      cfg_fmt_reg    <= '0;
      cfg_verif_reg  <= '0;
      cfg_len_reg    <= '0;
      cfg_hi_reg     <= 1'b0;
      cfg_blocks_reg <= '0;
      cfg_retx_reg   <= '0;
      cfg_flt_reg    <= ctc_pkg::FLT_NONE;
      cfg_fn_reg     <= ctc_pkg::ZERO_WORD;
    end
    else if (start_ok)
    begin
      cfg_pat_reg    <= ctc_pkg::ctc_pat_t'(pat_mode);
      cfg_user_reg   <= pat_user;
      cfg_addr_reg   <= payload_addr;
      cfg_fmt_reg    <= fmt_type;
      cfg_verif_reg  <= verif_sel;
      cfg_len_reg    <= blk_len;
      cfg_hi_reg     <= priority_hi;
      cfg_blocks_reg <= num_blocks;
      cfg_retx_reg   <= retx_cnt;
      cfg_flt_reg    <= fault_mode;
      cfg_fn_reg     <= fault_n;
    end
  end

  always_comb
  begin
    case (cfg_pat_reg)
      ctc_pkg::PAT_ZERO:  pat_word = ctc_pkg::ZERO_WORD;
      ctc_pkg::PAT_ONES:  pat_word = ctc_pkg::ONES_WORD;
      ctc_pkg::PAT_ALT:   pat_word = ctc_pkg::ALT_WORD;
      ctc_pkg::PAT_COUNT: pat_word = cnt_reg;
      ctc_pkg::PAT_USER:  pat_word = cfg_user_reg;
      default:            pat_word = ctc_pkg::ZERO_WORD;
    endcase
  end

  always_comb
  begin
    case (widx_reg[1:0])
      2'h0:    ci_word = {cfg_addr_reg, cfg_fmt_reg, cfg_verif_reg};
      2'h1:    ci_word = {cfg_retx_reg, 12'h000};
      2'h2:    ci_word = {7'h00, cfg_blocks_reg};
      default: ci_word = ctc_pkg::ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      g_st_reg <= ctc_pkg::G_IDLE;
    else if (stop && run_busy)
      g_st_reg <= ctc_pkg::G_DONE;
    else
      case (g_st_reg)
        ctc_pkg::G_IDLE, ctc_pkg::G_DONE:
          if (start_ok)
            g_st_reg <= ctc_pkg::G_CI;
        ctc_pkg::G_CI:
          if (widx_reg == 6'h03)
            g_st_reg <= ctc_pkg::G_DATA;
        ctc_pkg::G_DATA:
          if (widx_reg == cfg_len_reg - 6'h01)
            g_st_reg <= ctc_pkg::G_MSG;
        ctc_pkg::G_MSG:
          g_st_reg <= ctc_pkg::G_WAIT;
        ctc_pkg::G_WAIT:
          if (blk_taken)
            g_st_reg <= (blk_left_reg <= 9'h001) ? ctc_pkg::G_DONE : ctc_pkg::G_DATA;
        default:
          g_st_reg <= ctc_pkg::G_IDLE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst || start_ok)
      widx_reg <= '0;
    else if (g_st_reg == ctc_pkg::G_CI)
      widx_reg <= (widx_reg == 6'h03) ? 6'h00 : widx_reg + 6'h01;
    else if (g_st_reg == ctc_pkg::G_DATA)
      widx_reg <= widx_reg + 6'h01;
    else
      widx_reg <= '0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      blk_left_reg <= '0;
    else if (start_ok)
      blk_left_reg <= num_blocks;
    else if (g_st_reg == ctc_pkg::G_WAIT && blk_taken)
      blk_left_reg <= blk_left_reg - 9'h001;
  end

  always_ff @(posedge clk)
  begin
    if (rst || start_ok)
      cnt_reg <= ctc_pkg::ZERO_WORD;
    else if (g_st_reg == ctc_pkg::G_DATA && !stop)
      cnt_reg <= cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst || start_ok)
      first_reg <= 1'b1;
    else if (g_st_reg == ctc_pkg::G_MSG)
      first_reg <= 1'b0;
  end

  // memory port driven straight from flops, one word per clock
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_we    <= 1'b0;
      mem_addr  <= ctc_pkg::ZERO_WORD;
      mem_wdata <= ctc_pkg::ZERO_WORD;
    end
    else
    begin
      mem_we <= 1'b0;
      if (!stop)
        case (g_st_reg)
          ctc_pkg::G_CI:
          begin
            mem_we    <= 1'b1;
            mem_addr  <= ctc_pkg::CI_ADDR + {10'h000, widx_reg};
            mem_wdata <= ci_word;
          end
          ctc_pkg::G_DATA:
          begin
            mem_we    <= 1'b1;
            mem_addr  <= ctc_pkg::DATA_ADDR + {10'h000, widx_reg};
            mem_wdata <= pat_word;
          end
          ctc_pkg::G_MSG:
          begin
            mem_we    <= 1'b1;
            mem_addr  <= ctc_pkg::MSG_ADDR;
            mem_wdata <= ctc_pkg::ZERO_WORD;
            mem_wdata[ctc_pkg::MSG_HI_BIT]  <= cfg_hi_reg && first_reg;
            mem_wdata[ctc_pkg::MSG_NCI_BIT] <= first_reg;
            mem_wdata[ctc_pkg::MSG_NBD_BIT] <= 1'b1;
            mem_wdata[5:0] <= cfg_len_reg;
          end
          default:
            mem_we <= 1'b0;
        endcase
    end
  end

  for (genvar i = 0; i < ctc_pkg::COPY_D; i++)
  begin : g_copy
    always_ff @(posedge clk)
    begin
      if (rst)
        copy_reg[i] <= ctc_pkg::ZERO_WORD;
      else if (g_st_reg == ctc_pkg::G_DATA && !stop && widx_reg == 6'(i))
        copy_reg[i] <= pat_word;
    end
  end

  // performance monitor simulator
  logic [15:0] wnum_reg;
  logic [15:0] pos_reg;
  logic [15:0] nth_reg;
  logic        faulty;
  logic        bitwise;
  logic        late_on_reg;
  logic [19:0] late_cnt_reg;
  logic        late_fire;

  assign bitwise   = cfg_verif_reg[ctc_pkg::VAL_BBB_BIT];
  assign late_fire = late_on_reg && late_cnt_reg == 20'(VAL_WIN_CYC);

  always_comb
  begin
    case (cfg_flt_reg)
      ctc_pkg::FLT_WORD: faulty = wnum_reg == cfg_fn_reg;
      ctc_pkg::FLT_POS:  faulty = pos_reg == cfg_fn_reg;
      ctc_pkg::FLT_NTH:  faulty = nth_reg == cfg_fn_reg;
      default:           faulty = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst || start_ok)
    begin
      wnum_reg <= 16'h0001;
      pos_reg  <= 16'h0001;
      nth_reg  <= 16'h0001;
    end
    else if (tx_valid)
    begin
      wnum_reg <= wnum_reg + 16'h0001;
      pos_reg  <= (pos_reg == {10'h000, cfg_len_reg}) ? 16'h0001 : pos_reg + 16'h0001;
      nth_reg  <= (nth_reg == cfg_fn_reg) ? 16'h0001 : nth_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pms_valid <= 1'b0;
      pms_word  <= ctc_pkg::ZERO_WORD;
    end
    else
    begin
      pms_valid <= tx_valid;
      if (tx_valid)
        pms_word <= (faulty && bitwise) ? tx_word ^ ctc_pkg::FLIP_MASK : tx_word;
    end
  end

  // a withheld ack comes one cycle past the window so overdue is seen
  always_ff @(posedge clk)
  begin
    if (rst || start_ok)
    begin
      late_on_reg  <= 1'b0;
      late_cnt_reg <= '0;
    end
    else if (tx_valid && faulty && !bitwise)
    begin
      late_on_reg  <= 1'b1;
      late_cnt_reg <= '0;
    end
    else if (late_fire)
      late_on_reg <= 1'b0;
    else if (late_on_reg)
      late_cnt_reg <= late_cnt_reg + 20'h00001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pms_ack <= 1'b0;
    else
      pms_ack <= (tx_valid && !(faulty && !bitwise)) || late_fire;
  end

  // encrypter loopback
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lb_valid <= 1'b0;
      lb_sym   <= ctc_pkg::SYM_ZERO;
    end
    else
    begin
      lb_valid <= enc_in_valid;
      if (enc_in_valid)
        case (enc_in_sym)
          ctc_pkg::SYM_PLUS:  lb_sym <= lb_invert ? ctc_pkg::SYM_MINUS : ctc_pkg::SYM_PLUS;
          ctc_pkg::SYM_MINUS: lb_sym <= lb_invert ? ctc_pkg::SYM_PLUS : ctc_pkg::SYM_MINUS;
          default:            lb_sym <= ctc_pkg::SYM_ZERO;
        endcase
    end
  end

  // voice pattern source
  logic [3:0] vcnt_reg;
  logic [3:0] wpos_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vcnt_reg  <= '0;
      wpos_reg  <= '0;
      voice_bit <= 1'b0;
    end
    else if (voice_tick)
    begin
      vcnt_reg <= vcnt_reg + 4'h1;
      if (vcnt_reg == 4'hf)
        wpos_reg <= wpos_reg + 4'h1;
      case (ctc_pkg::ctc_voice_t'(voice_pat))
        ctc_pkg::VOI_ALT1: voice_bit <= vcnt_reg[0];
        ctc_pkg::VOI_ALT2: voice_bit <= vcnt_reg[1];
        ctc_pkg::VOI_WALK: voice_bit <= vcnt_reg == wpos_reg;
        default:           voice_bit <= 1'b0;
      endcase
    end
  end

  // demodulated data checker
  ctc_bch_if bi ();
  ctc_bch_enc u_bch (
    .clk (clk),
    .rst (rst),
    .b   (bi.gen)
  );

  logic [15:0]             rx_sh_reg;
  logic [15:0]             rx_w;
  logic                    synced_reg;
  logic [3:0]              bitcnt_reg;
  logic [5:0]              ridx_reg;
  logic [5:0]              last_idx;
  logic                    word_ev;
  logic                    data_bad;
  logic                    par_bad;
  logic                    frame_end;
  logic                    seen_reg;
  logic [ctc_pkg::PAR_W-1:0] rx_par_reg;
  logic [ctc_pkg::HIST_D-1:0] hist_reg;

  assign rx_w      = {rx_sh_reg[14:0], rx_bit};
  assign last_idx  = bch_mode ? 6'h03 : cfg_len_reg - 6'h01;
  assign word_ev   = rx_valid && !halted && synced_reg && bitcnt_reg == 4'hf;
  assign data_bad  = word_ev && !(bch_mode && ridx_reg == 6'h03)
                   && rx_w != copy_reg[ridx_reg];
  assign par_bad   = bi.done && bi.parity != rx_par_reg;
  assign frame_end = word_ev && ridx_reg == last_idx;
  assign bi.start  = word_ev && bch_mode && ridx_reg == 6'h03;
  assign bi.info   = {copy_reg[0], copy_reg[1], copy_reg[2]};

  always_ff @(posedge clk)
  begin
    if (rst || start_ok)
    begin
      rx_sh_reg  <= ctc_pkg::ZERO_WORD;
      synced_reg <= 1'b0;
      bitcnt_reg <= '0;
      ridx_reg   <= '0;
    end
    else if (rx_valid && !halted)
    begin
      rx_sh_reg <= rx_w;
      if (!synced_reg)
      begin
        if (rx_w == ctc_pkg::SYNC_WORD)
          synced_reg <= 1'b1;
        bitcnt_reg <= '0;
        ridx_reg   <= '0;
      end
      else
      begin
        bitcnt_reg <= bitcnt_reg + 4'h1;
        if (bitcnt_reg == 4'hf)
        begin
          ridx_reg <= ridx_reg + 6'h01;
          if (ridx_reg == last_idx)
            synced_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_word_valid <= 1'b0;
      rx_word       <= ctc_pkg::ZERO_WORD;
      rx_par_reg    <= '0;
    end
    else
    begin
      rx_word_valid <= word_ev;
      if (word_ev)
        rx_word <= rx_w;
      if (bi.start)
        rx_par_reg <= rx_w[ctc_pkg::PAR_W-1:0];
    end
  end

  // a mismatch in the start cycle still wins over the clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      halted     <= 1'b0;
      parity_err <= 1'b0;
    end
    else
    begin
      halted     <= (halted && !start_ok) || data_bad || par_bad;
      parity_err <= (parity_err && !start_ok) || par_bad;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || start_ok)
    begin
      blk_rx_cnt  <= ctc_pkg::ZERO_WORD;
      retx_rx_cnt <= ctc_pkg::ZERO_WORD;
    end
    else if (frame_end && !data_bad)
    begin
      if (seen_reg)
        retx_rx_cnt <= retx_rx_cnt + 16'h0001;
      else
        blk_rx_cnt <= blk_rx_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || start_ok)
      seen_reg <= 1'b0;
    else
      seen_reg <= frame_end || (seen_reg && g_st_reg != ctc_pkg::G_MSG);
  end

  // history freezes with the halt so the failing bits stay readable
  always_ff @(posedge clk)
  begin
    if (rst)
      hist_reg <= '0;
    else if (rx_valid && !halted)
      hist_reg <= {hist_reg[ctc_pkg::HIST_D-2:0], rx_bit};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      hist_bit <= 1'b0;
    else
      hist_bit <= hist_reg[hist_sel];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_halt_sticky: assert property (halted && !run_start |=> halted)
    else $error("halt dropped without run start");
  a_halt_holds: assert property (halted && !run_start
                                 |=> $stable(blk_rx_cnt) && $stable(hist_reg))
    else $error("recorded state changed while halted");
  a_mismatch_halt: assert property (data_bad |=> halted ##1 (halted && !rx_word_valid)[*2])
    else $error("mismatch did not halt");
  a_parity_flag: assert property (par_bad |=> parity_err && halted)
    else $error("parity difference not flagged");
  a_loop_invert: assert property (enc_in_valid && lb_invert && enc_in_sym == 2'h1
                                  |=> lb_valid && lb_sym == 2'h2)
    else $error("loopback did not invert");
  a_loop_plain: assert property (enc_in_valid && !lb_invert |=> lb_sym == $past(enc_in_sym))
    else $error("loopback altered symbol");
  a_count_wrap: assert property (g_st_reg == ctc_pkg::G_DATA && !stop && cnt_reg == 16'hffff
                                 |=> cnt_reg == 16'h0000)
    else $error("count pattern did not wrap");
  a_count_step: assert property (g_st_reg == ctc_pkg::G_DATA && !stop
                                 |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("count pattern did not step");
  a_ones_data: assert property (g_st_reg == ctc_pkg::G_DATA && !stop
                                && cfg_pat_reg == ctc_pkg::PAT_ONES
                                |=> mem_we && mem_wdata == 16'hffff)
    else $error("all ones pattern wrong");
  a_bit_flip: assert property (tx_valid && faulty && bitwise
                               |=> pms_valid && pms_word != $past(tx_word) && pms_ack)
    else $error("faulty word not corrupted");
  a_ack_withheld: assert property (tx_valid && faulty && !bitwise && !late_fire
                                   |=> !pms_ack)
    else $error("faulty word acknowledged in time");
  a_cfg_stable: assert property (run_busy |=> $stable(cfg_len_reg) && $stable(cfg_pat_reg))
    else $error("settings changed during run");
  a_hist_shift: assert property (rx_valid && !halted |=> hist_reg[0] == $past(rx_bit))
    else $error("history missed a bit");

  c_full_run: cover property (g_st_reg == ctc_pkg::G_WAIT && blk_taken
                              && blk_left_reg == 9'h001);
  c_retx_seen: cover property (frame_end && seen_reg);
  c_parity_bad: cover property (par_bad);
  c_late_ack: cover property (late_fire);
endmodule

// ==== test/ctc_enc_model.sv ====
// two-port memory model of the encoder side
`timescale 1ns/100ps
module ctc_enc_model (
  input  wire logic        clk,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             blk_taken
);
  logic [15:0] mem [0:255];
  logic [2:0]  tk;
  initial
  begin
    tk = 3'h0;
    blk_taken = 1'b0;
  end
  // block consumed a few cycles after its message word, like a slow encoder
  always @(posedge clk)
  begin
    if (mem_we)
      mem[mem_addr[7:0]] <= mem_wdata;
    tk <= {tk[1:0], mem_we && mem_addr === ctc_pkg::MSG_ADDR};
    blk_taken <= tk[2];
  end
endmodule

// ==== test/tb_ctc_top.sv ====
// self-checking bench of the command encoder test checker
`timescale 1ns/100ps
module tb_ctc_top;
  logic        clk, rst, run_start, priority_hi, blk_taken, mem_we, tx_valid, pms_valid;
  logic        pms_ack, enc_in_valid, lb_invert, lb_valid, voice_tick, voice_bit, rx_valid;
  logic        rx_bit, bch_mode, rx_word_valid, halted, parity_err, hist_bit, run_busy;
  logic [15:0] pat_user, fault_n, mem_addr, mem_wdata, tx_word, pms_word, rx_word, v;
  logic [15:0] blk_rx_cnt, retx_rx_cnt;
  logic [8:0]  num_blocks;
  logic [7:0]  payload_addr, hist_sel;
  logic [5:0]  blk_len;
  logic [4:0]  fmt_type;
  logic [3:0]  retx_cnt;
  logic [2:0]  pat_mode, verif_sel;
  logic [1:0]  fault_mode, enc_in_sym, lb_sym, voice_pat;
  int          error_cnt, n_checks, n;
  localparam logic [15:0] E0 [5] = '{16'h0000, 16'hffff, 16'h5555, 16'h0000, 16'hc3a7};
  localparam logic [15:0] E1 [5] = '{16'h0000, 16'hffff, 16'h5555, 16'h0001, 16'hc3a7};

  // short window keeps the late acknowledgement test brief
  ctc_top #(.VAL_WIN_CYC(20)) ctc_top_inst (.*);
  ctc_enc_model ctc_enc_model_inst (.clk, .mem_we, .mem_addr, .mem_wdata, .blk_taken);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic step;
    @(posedge clk) #1;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // reference parity: plain long division of the 48 info bits
  function automatic logic [14:0] bch_ref(input logic [47:0] d);
    logic [14:0] r;
    r = 15'h0000;
    for (int i = 47; i >= 0; i--)
      r = {r[13:0], 1'b0} ^ (d[i] ^ r[14] ? ctc_pkg::BCH_POLY : 15'h0000);
    return r;
  endfunction

  task automatic run(input logic [2:0] pm, input logic [15:0] u);
    int i;
    pat_mode = pm;
    pat_user = u;
    run_start = 1'b1;
    step;
    run_start = 1'b0;
    for (i = 0; i < 300 && (i < 3 || run_busy); i++)
      step;
    if (i == 300)
    begin
      error_cnt++;
      complete_run;
    end
  endtask

  task automatic tx(input logic [15:0] w);
    step;
    tx_valid = 1'b1;
    tx_word = w;
    step;
    tx_valid = 1'b0;
  endtask

  task automatic rxw(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      rx_valid = 1'b1;
      rx_bit = w[i];
      step;
    end
  endtask

  initial
  begin
    rst = 1'b1;
    {run_start, tx_valid, enc_in_valid, lb_invert, voice_tick, rx_valid, rx_bit} = '0;
    {bch_mode, pat_user, fault_n, tx_word, hist_sel, pat_mode, fault_mode} = '0;
    {enc_in_sym, voice_pat} = '0;
    {payload_addr, fmt_type, verif_sel, blk_len} = {8'h3c, 5'h05, 3'h1, 6'h02};
    {priority_hi, num_blocks, retx_cnt} = {1'b1, 9'h001, 4'h3};
    error_cnt = 0;
    n_checks = 0;
    repeat (8) step;
    rst = 1'b0;
    for (int m = 0; m < 5; m++)
    begin
      run(3'(m), 16'hc3a7);
      chk(ctc_enc_model_inst.mem[8'h40], E0[m]);
      chk(ctc_enc_model_inst.mem[8'h41], E1[m]);
    end
    chk(ctc_enc_model_inst.mem[8'h10], 16'h3c29);
    chk(16'(ctc_enc_model_inst.mem[8'h11][15:12]), 16'h0003);
    chk(ctc_enc_model_inst.mem[8'hd0], 16'he002);
    $display("test patterns done");
    {fault_mode, fault_n} = {2'h3, 16'h0002};
    run(3'h0, 16'h0000);
    tx(16'h00a5);
    chk({pms_word[14:0], pms_ack}, 16'h014b);
    tx(16'h00a5);
    chk({pms_word[14:0], pms_ack}, 16'h0149);
    {verif_sel, fault_mode, fault_n} = {3'h0, 2'h1, 16'h0001};
    run(3'h0, 16'h0000);
    tx(16'h0f0f);
    for (n = 0; n < 40 && pms_ack !== 1'b1; n++)
      step;
    chk(16'(n), 16'd21);
    {verif_sel, fault_mode, fault_n} = {3'h1, 2'h2, 16'h0002};
    run(3'h0, 16'h0000);
    for (n = 0; n < 3; n++)
    begin
      tx(16'h00a5);
      chk({pms_valid, pms_word[14:0]}, {1'b1, 15'h00a5 ^ 15'(n == 1)});
    end
    $display("test monitor done");
    enc_in_valid = 1'b1;
    for (n = 0; n < 6; n++)
    begin
      {lb_invert, enc_in_sym} = {n[0], 2'(n >> 1)};
      step;
      chk(16'({lb_valid, lb_sym}), 16'({1'b1, lb_invert && enc_in_sym != 0 ? 2'h3 - enc_in_sym : enc_in_sym}));
    end
    enc_in_valid = 1'b0;
    $display("test loopback done");
    for (int p = 0; p < 3; p++)
    begin
      voice_pat = 2'(p);
      for (n = 0; n < 16; n++)
      begin
        voice_tick = 1'b1;
        step;
        voice_tick = 1'b0;
        step;
        v[n] = voice_bit;
      end
      if (p < 2)
        chk(p == 0 ? v ^ (v >> 1) | 16'h8000 : v ^ (v >> 2) | 16'hc000, 16'hffff);
      else
        chk(16'($countones(v)), 16'h0001);
    end
    $display("test voice done");
    blk_len = 6'h01;
    run(3'h4, 16'h1234);
    hist_sel = 8'h02;
    for (n = 0; n < 4; n++)
    begin
      rxw(ctc_pkg::SYNC_WORD);
      rxw(n == 2 ? 16'h1235 : 16'h1234);
      chk(16'(rx_word_valid), 16'(n != 3));
      rx_valid = 1'b0;
      repeat (3) step;
      chk(16'(halted), 16'(n >= 2));
      if (n == 1)
      begin
        chk(rx_word, 16'h1234);
        chk(16'(hist_bit), 16'h0001);
      end
    end
    chk(blk_rx_cnt, 16'h0001);
    chk(retx_rx_cnt, 16'h0001);
    {bch_mode, blk_len} = {1'b1, 6'h03};
    for (n = 0; n < 2; n++)
    begin
      run(3'h4, 16'h1234);
      rxw(ctc_pkg::SYNC_WORD);
      repeat (3) rxw(16'h1234);
      rxw({1'b0, bch_ref({3{16'h1234}})} ^ 16'(n));
      rx_valid = 1'b0;
      repeat (3) step;
      chk(16'({parity_err, halted}), 16'(n * 3));
    end
    $display("test receive done");
    complete_run;
  end
endmodule
